/* gbsc_params.svh */
`ifndef GBSC_PARAMS_SVH
`define GBSC_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define GBSC_P0_DATA_ADDR 32'hffff0d20
`define GBSC_P0_SET_ADDR 32'hffff0d24
`define GBSC_P0_CLR_ADDR 32'hffff0d28
`define GBSC_P1_DATA_ADDR 32'hffff0d30
`define GBSC_P1_SET_ADDR 32'hffff0d34
`define GBSC_P1_CLR_ADDR 32'hffff0d38
`define GBSC_P2_DATA_ADDR 32'hffff0d40
`define GBSC_P2_SET_ADDR 32'hffff0d44
`define GBSC_P2_CLR_ADDR 32'hffff0d48

// ****************************************
// Field positions and pin masks
// ****************************************
`define GBSC_IN_LSB 0
`define GBSC_OUT_LSB 16
`define GBSC_DIR_LSB 24
`define GBSC_P0_MASK 7'h1f
`define GBSC_P1_MASK 7'h03
`define GBSC_P2_MASK 7'h63
`define GBSC_P2_IN_MASK 7'h73

// ****************************************
// Reset values
// ****************************************
`define GBSC_LATCH_RST 7'h00
`define GBSC_DIR_RST 7'h00
`define GBSC_RDATA_RST 32'h0000_0000

`endif

/* gbsc_pkg.sv */
package gbsc_pkg;

  // ****************************************
  // Register port request
  // ****************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gbsc_req_t;

  // ****************************************
  // Module state
  // ****************************************
  typedef struct packed {
    logic [6:0] latch;
    logic [6:0] dir;
    logic [6:0] sync1;
    logic [6:0] sync2;
  } gbsc_port_st_t;

  typedef struct packed {
    logic [31:0] rdata;
  } gbsc_top_st_t;

endpackage

/* gbsc_port.sv */
`timescale 1ns/1ps
`include "gbsc_params.svh"

module gbsc_port #(
  parameter logic [6:0] OUT_MASK = 7'h7f,
  parameter logic [6:0] IN_MASK = 7'h7f
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic set_en,
  input wire logic clr_en,
  input wire logic dat_en,
  input wire logic [6:0] wbits,
  input wire logic [6:0] wdir,
  input wire logic [6:0] pin_in,
  output logic [6:0] latch,
  output logic [6:0] oe,
  output logic [31:0] rd_word
);
  import gbsc_pkg::*;

  // ****************************************
  // State
  // ****************************************
  gbsc_port_st_t st;
  gbsc_port_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    if (dat_en) begin
      next_st.latch = wbits & OUT_MASK;
      next_st.dir = wdir & OUT_MASK;
    end else if (set_en) begin
      next_st.latch = st.latch | (wbits & OUT_MASK);
    end else if (clr_en) begin
      next_st.latch = st.latch & ~(wbits & OUT_MASK);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.latch <= `GBSC_LATCH_RST;
      st.dir <= `GBSC_DIR_RST;
      st.sync1 <= 7'h00;
      st.sync2 <= 7'h00;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign latch = st.latch;
  assign oe = st.dir;
  assign rd_word = {1'b0, st.dir, 1'b0, st.latch, 9'h000,
    st.sync2 & IN_MASK};

endmodule

/* gbsc_top.sv */
// Function
// - Port 0 set bits 16-20 drive pins 0-4 high.
// - Set bits written as zero leave their pins unchanged.
// - Port 1 set bits 16-17 drive pins 0-1 high.
// - Port 2 set bits 16,17,21,22 drive pins 0,1,5,6 high.
// - Port 0 clear bits 16-20 drive pins 0-4 low.
// - Clear bits written as zero leave their pins unchanged.
// - Port 1 clear bits 16-17 drive pins 0-1 low.
// - Set and clear registers are 32-bit write-only, touching only their pins.
// - Port 2 clear bits 16,17,21,22 drive pins 0,1,5,6 low.
// - Latch drives pin; data, set, clear share it; direction enables.
`timescale 1ns/1ps
`include "gbsc_params.svh"

module gbsc_top (
  input wire logic mclk,
  input wire logic rst,
  input wire gbsc_pkg::gbsc_req_t req,
  output logic [31:0] rdata,
  input wire logic [4:0] p0_in,
  output logic [4:0] p0_out,
  output logic [4:0] p0_oe,
  input wire logic [1:0] p1_in,
  output logic [1:0] p1_out,
  output logic [1:0] p1_oe,
  input wire logic [6:0] p2_in,
  output logic [6:0] p2_out,
  output logic [6:0] p2_oe
);
  import gbsc_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  logic wr_p0d;
  logic wr_p0s;
  logic wr_p0c;
  logic wr_p1d;
  logic wr_p1s;
  logic wr_p1c;
  logic wr_p2d;
  logic wr_p2s;
  logic wr_p2c;
  logic [6:0] w_bits;
  logic [6:0] w_dir;
  logic wr_any;

  assign wr_p0d = req.wr && (req.addr == `GBSC_P0_DATA_ADDR);
  assign wr_p0s = req.wr && (req.addr == `GBSC_P0_SET_ADDR);
  assign wr_p0c = req.wr && (req.addr == `GBSC_P0_CLR_ADDR);
  assign wr_p1d = req.wr && (req.addr == `GBSC_P1_DATA_ADDR);
  assign wr_p1s = req.wr && (req.addr == `GBSC_P1_SET_ADDR);
  assign wr_p1c = req.wr && (req.addr == `GBSC_P1_CLR_ADDR);
  assign wr_p2d = req.wr && (req.addr == `GBSC_P2_DATA_ADDR);
  assign wr_p2s = req.wr && (req.addr == `GBSC_P2_SET_ADDR);
  assign wr_p2c = req.wr && (req.addr == `GBSC_P2_CLR_ADDR);
  assign wr_any = wr_p0d || wr_p0s || wr_p0c || wr_p1d || wr_p1s || wr_p1c
    || wr_p2d || wr_p2s || wr_p2c;

  // Reserved bits are masked off inside each port
  assign w_bits = req.wdata[`GBSC_OUT_LSB +: 7];
  assign w_dir = req.wdata[`GBSC_DIR_LSB +: 7];

  // ****************************************
  // Port instances
  // ****************************************
  logic [6:0] l0;
  logic [6:0] l1;
  logic [6:0] l2;
  logic [6:0] e0;
  logic [6:0] e1;
  logic [6:0] e2;
  logic [31:0] rw0;
  logic [31:0] rw1;
  logic [31:0] rw2;

  gbsc_port #(
    .OUT_MASK(`GBSC_P0_MASK),
    .IN_MASK(`GBSC_P0_MASK)
  ) u_port0 (
    .mclk(mclk),
    .rst(rst),
    .set_en(wr_p0s),
    .clr_en(wr_p0c),
    .dat_en(wr_p0d),
    .wbits(w_bits),
    .wdir(w_dir),
    .pin_in({2'b00, p0_in}),
    .latch(l0),
    .oe(e0),
    .rd_word(rw0)
  );

  gbsc_port #(
    .OUT_MASK(`GBSC_P1_MASK),
    .IN_MASK(`GBSC_P1_MASK)
  ) u_port1 (
    .mclk(mclk),
    .rst(rst),
    .set_en(wr_p1s),
    .clr_en(wr_p1c),
    .dat_en(wr_p1d),
    .wbits(w_bits),
    .wdir(w_dir),
    .pin_in({5'h00, p1_in}),
    .latch(l1),
    .oe(e1),
    .rd_word(rw1)
  );

  gbsc_port #(
    .OUT_MASK(`GBSC_P2_MASK),
    .IN_MASK(`GBSC_P2_IN_MASK)
  ) u_port2 (
    .mclk(mclk),
    .rst(rst),
    .set_en(wr_p2s),
    .clr_en(wr_p2c),
    .dat_en(wr_p2d),
    .wbits(w_bits),
    .wdir(w_dir),
    .pin_in(p2_in),
    .latch(l2),
    .oe(e2),
    .rd_word(rw2)
  );

  // ****************************************
  // Pin outputs
  // ****************************************
  assign p0_out = l0[4:0];
  assign p0_oe = e0[4:0];
  assign p1_out = l1[1:0];
  assign p1_oe = e1[1:0];
  assign p2_out = l2;
  assign p2_oe = e2;

  // ****************************************
  // Read path
  // ****************************************
  gbsc_top_st_t st;
  gbsc_top_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.rdata = 32'h0000_0000;
    if (req.rd) begin
      case (req.addr)
        `GBSC_P0_DATA_ADDR: next_st.rdata = rw0;
        `GBSC_P1_DATA_ADDR: next_st.rdata = rw1;
        `GBSC_P2_DATA_ADDR: next_st.rdata = rw2;
        `GBSC_P0_SET_ADDR,
        `GBSC_P0_CLR_ADDR,
        `GBSC_P1_SET_ADDR,
        `GBSC_P1_CLR_ADDR,
        `GBSC_P2_SET_ADDR,
        `GBSC_P2_CLR_ADDR: begin
          next_st.rdata = 32'h0000_0000;
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.rdata <= `GBSC_RDATA_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;

  // ****************************************
  // Checks
  // ****************************************
  logic [31:0] h_wd;
  logic h_rd_sc;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      h_wd <= 32'h0000_0000;
      h_rd_sc <= 1'b0;
    end else begin
      h_wd <= req.wdata;
      h_rd_sc <= req.rd && (req.addr[3:0] == 4'h4 || req.addr[3:0] == 4'h8)
        && (req.addr[31:8] == 24'hffff0d);
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  property p_set0;
    wr_p0s |=> ((p0_out & h_wd[20:16]) == h_wd[20:16]);
  endproperty
  a_set0: assert property (p_set0)
    else $error("port 0 set bit did not drive pin high");

  property p_set_keep;
    wr_p0s |=> ((p0_out & ~h_wd[20:16]) == ($past(p0_out) & ~h_wd[20:16]));
  endproperty
  a_set_keep: assert property (p_set_keep)
    else $error("port 0 set zero bit changed a pin");

  property p_set1;
    wr_p1s |=> (p1_out == ($past(p1_out) | h_wd[17:16]));
  endproperty
  a_set1: assert property (p_set1)
    else $error("port 1 set result wrong");

  property p_set2;
    wr_p2s |=> (p2_out == ($past(p2_out)
      | {h_wd[22:21], 3'b000, h_wd[17:16]}));
  endproperty
  a_set2: assert property (p_set2)
    else $error("port 2 set result wrong");

  property p_clr0;
    wr_p0c |=> ((p0_out & h_wd[20:16]) == 5'h00);
  endproperty
  a_clr0: assert property (p_clr0)
    else $error("port 0 clear bit did not drive pin low");

  property p_clr_keep;
    wr_p0c |=> ((p0_out & ~h_wd[20:16]) == ($past(p0_out) & ~h_wd[20:16]));
  endproperty
  a_clr_keep: assert property (p_clr_keep)
    else $error("port 0 clear zero bit changed a pin");

  property p_clr1;
    wr_p1c |=> (p1_out == ($past(p1_out) & ~h_wd[17:16]));
  endproperty
  a_clr1: assert property (p_clr1)
    else $error("port 1 clear result wrong");

  property p_other;
    (wr_p0s || wr_p0c) |=> ($stable(p1_out) && $stable(p2_out)
      && $stable(p0_oe));
  endproperty
  a_other: assert property (p_other)
    else $error("port 0 set or clear touched another pin");

  property p_clr2;
    wr_p2c |=> (p2_out == ($past(p2_out)
      & ~{h_wd[22:21], 3'b000, h_wd[17:16]}));
  endproperty
  a_clr2: assert property (p_clr2)
    else $error("port 2 clear result wrong");

  property p_dat;
    wr_p2d |=> (p2_out == (h_wd[22:16] & 7'h63))
      && (p2_oe == (h_wd[30:24] & 7'h63));
  endproperty
  a_dat: assert property (p_dat)
    else $error("data word write did not reach latch and direction");

  property p_rd_zero;
    h_rd_sc |-> (rdata == 32'h0000_0000) && $stable(p0_out)
      && $stable(p1_out) && $stable(p2_out);
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("read of set or clear register not zero or had effect");

  property p_idle;
    !req.rd |=> (rdata == 32'h0000_0000);
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data not zero outside a read answer");

  property p_other1;
    (wr_p1s || wr_p1c) |=> ($stable(p0_out) && $stable(p2_out)
      && $stable(p1_oe));
  endproperty
  a_other1: assert property (p_other1)
    else $error("port 1 set or clear touched another pin");

  property p_other2;
    (wr_p2s || wr_p2c) |=> ($stable(p0_out) && $stable(p1_out)
      && $stable(p2_oe));
  endproperty
  a_other2: assert property (p_other2)
    else $error("port 2 set or clear touched another pin");

  property p_dat0;
    wr_p0d |=> (p0_out == h_wd[20:16]) && (p0_oe == h_wd[28:24]);
  endproperty
  a_dat0: assert property (p_dat0)
    else $error("port 0 data word did not reach latch and direction");

  property p_dat1;
    wr_p1d |=> (p1_out == h_wd[17:16]) && (p1_oe == h_wd[25:24]);
  endproperty
  a_dat1: assert property (p_dat1)
    else $error("port 1 data word did not reach latch and direction");

  property p_rd_dat0;
    req.rd && (req.addr == `GBSC_P0_DATA_ADDR) |=> (rdata[31:7]
      == {3'b000, $past(p0_oe), 3'b000, $past(p0_out), 9'h000})
      && (rdata[6:0] == {2'b00, $past(p0_in, 3)});
  endproperty
  a_rd_dat0: assert property (p_rd_dat0)
    else $error("port 0 data word read back wrong");

  property p_rd_dat1;
    req.rd && (req.addr == `GBSC_P1_DATA_ADDR) |=> (rdata[31:7]
      == {6'h00, $past(p1_oe), 6'h00, $past(p1_out), 9'h000})
      && (rdata[6:0] == {5'h00, $past(p1_in, 3)});
  endproperty
  a_rd_dat1: assert property (p_rd_dat1)
    else $error("port 1 data word read back wrong");

  property p_rd_dat2;
    req.rd && (req.addr == `GBSC_P2_DATA_ADDR) |=> (rdata[31:7]
      == {1'b0, $past(p2_oe), 1'b0, $past(p2_out), 9'h000})
      && (rdata[6:0] == ($past(p2_in, 3) & `GBSC_P2_IN_MASK));
  endproperty
  a_rd_dat2: assert property (p_rd_dat2)
    else $error("port 2 data word read back wrong");

  property p_p2_gap;
    (p2_out[4:2] == 3'b000) && (p2_oe[4:2] == 3'b000);
  endproperty
  a_p2_gap: assert property (p_p2_gap)
    else $error("port 2 pin without output was driven");

  property p_unmapped;
    req.wr && !wr_any |=> $stable(p0_out) && $stable(p1_out)
      && $stable(p2_out) && $stable(p0_oe) && $stable(p1_oe)
      && $stable(p2_oe);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("write to an unmapped address changed a pin");

  property p_rd_keep;
    !req.wr |=> $stable(p0_out) && $stable(p1_out)
      && $stable(p2_out) && $stable(p0_oe) && $stable(p1_oe)
      && $stable(p2_oe);
  endproperty
  a_rd_keep: assert property (p_rd_keep)
    else $error("pins changed in a cycle with no write");

  property p_oe_keep;
    (wr_p0s || wr_p0c || wr_p1s || wr_p1c || wr_p2s || wr_p2c)
      |=> $stable(p0_oe) && $stable(p1_oe) && $stable(p2_oe);
  endproperty
  a_oe_keep: assert property (p_oe_keep)
    else $error("set or clear write changed a direction");

endmodule

/* gbsc_pins.sv */
`timescale 1ns/1ps

// ****************************************
// External pins of one port
// ****************************************
module gbsc_pins (
  input wire logic [6:0] out,
  input wire logic [6:0] oe,
  input wire logic [6:0] ext,
  output logic [6:0] pin
);
  // Driven pins follow the latch, the others take the board level
  assign pin = (oe & out) | (~oe & ext);
endmodule

/* testbench.sv */
`timescale 1ns/1ps
`include "gbsc_params.svh"

// ****************************************
// Bench
// ****************************************
module testbench;
  import gbsc_pkg::*;
  localparam logic [6:0] MSK [3] = '{`GBSC_P0_MASK, `GBSC_P1_MASK,
    `GBSC_P2_MASK};
  localparam logic [6:0] IMSK [3] = '{`GBSC_P0_MASK, `GBSC_P1_MASK,
    `GBSC_P2_IN_MASK};
  localparam logic [31:0] BASE [3] = '{`GBSC_P0_DATA_ADDR,
    `GBSC_P1_DATA_ADDR, `GBSC_P2_DATA_ADDR};
  logic mclk = 1'b0;
  logic rst = 1'b1;
  gbsc_req_t req = '0;
  logic [31:0] rdata;
  logic [4:0] p0_out, p0_oe;
  logic [1:0] p1_out, p1_oe;
  logic [6:0] p2_out, p2_oe, pin0, pin1, pin2;
  logic [6:0] ext [3] = '{7'h00, 7'h00, 7'h00};
  logic [6:0] lat [3] = '{7'h00, 7'h00, 7'h00};
  logic [6:0] dir [3] = '{7'h00, 7'h00, 7'h00};
  logic [59:0] expq [$];
  logic pend = 1'b0;
  logic [31:0] seed = 32'd69108;
  logic [31:0] x, a, d;
  int n_errors = 0;
  int n_compared = 0;
  int i, k, p;

  always #2.5 mclk = ~mclk;

  gbsc_top dut (.mclk(mclk), .rst(rst), .req(req), .rdata(rdata),
    .p0_in(pin0[4:0]), .p0_out(p0_out), .p0_oe(p0_oe),
    .p1_in(pin1[1:0]), .p1_out(p1_out), .p1_oe(p1_oe),
    .p2_in(pin2), .p2_out(p2_out), .p2_oe(p2_oe));
  gbsc_pins u_pin0 (.out({2'b00, p0_out}), .oe({2'b00, p0_oe}),
    .ext(ext[0]), .pin(pin0));
  gbsc_pins u_pin1 (.out({5'h00, p1_out}), .oe({5'h00, p1_oe}),
    .ext(ext[1]), .pin(pin1));
  gbsc_pins u_pin2 (.out(p2_out), .oe(p2_oe), .ext(ext[2]), .pin(pin2));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(input logic [59:0] seen, input logic [59:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t expected %h seen %h", $time, exp, seen);
    end
  endtask

  task close_out();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Driver with reference model
  // ****************************************
  task acc(input logic w, input logic [31:0] ad, input logic [31:0] dd);
    logic [31:0] r;
    logic [6:0] b;
    r = '0;
    for (int q = 0; q < 3; q++) begin
      b = dd[22:16] & MSK[q];
      if (w && ad == BASE[q]) begin
        lat[q] = b;
        dir[q] = dd[30:24] & MSK[q];
      end
      if (w && ad == BASE[q] + 4) lat[q] |= b;
      if (w && ad == BASE[q] + 8) lat[q] &= ~b;
      if (!w && ad == BASE[q]) r = {1'b0, dir[q], 1'b0, lat[q], 9'h000,
        ((dir[q] & lat[q]) | (~dir[q] & ext[q])) & IMSK[q]};
    end
    expq.push_back({r, lat[2], lat[1][1:0], lat[0][4:0],
      dir[2], dir[1][1:0], dir[0][4:0]});
    req.addr <= ad;
    req.wdata <= dd;
    req.wr <= w;
    req.rd <= !w;
    @(posedge mclk);
  endtask

  task idle(input int n);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask

  // ****************************************
  // Output monitor
  // ****************************************
  always @(posedge mclk) begin
    if (pend && !rst) begin
      chk({rdata, p2_out, p1_out, p0_out, p2_oe, p1_oe, p0_oe},
        expq.pop_front());
    end
    pend <= (req.wr | req.rd) & !rst;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    close_out();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    for (p = 0; p < 3; p++) begin
      acc(1'b1, BASE[p] + 4, 32'hffffffff & {9'h0, MSK[p], 16'h0});
      acc(1'b0, BASE[p] + 4, 32'h0);
      acc(1'b1, BASE[p] + 8, {9'h0, MSK[p], 16'h0});
    end
    for (i = 0; i < 400; i++) begin
      x = rnd();
      d = rnd();
      k = x % 10;
      a = 32'hffff0d2c;
      if (k < 9) begin
        a = BASE[k / 3] + 4 * (k % 3);
        if (k % 3 == 0) begin
          d &= {1'b0, MSK[k / 3], 1'b0, MSK[k / 3], 16'h0};
        end else begin
          d &= {9'h0, MSK[k / 3], 16'h0};
        end
      end
      if (!x[8] && k < 9 && k % 3 == 0) begin
        ext[k / 3] <= d[6:0] ^ x[22:16];
        idle(4);
      end
      acc(x[8], a, d);
    end
    idle(3);
    close_out();
  end
endmodule
